// *** core/ccs_clk_mux.sv ***
// Glitch-free selector of master clock ticks between PLL and external source.
// Assumes both tick inputs are single-cycle pulses in the hclk domain.
`timescale 1ns/1ps
module ccs_clk_mux
	import ccs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick_pll,
	input wire logic tick_ext,
	input wire logic use_pll,
	output logic mclk_tick,
	output logic on_pll,
	output logic busy
);
	typedef struct packed {
		logic cur;
		logic busy;
		logic tick;
	} ccs_mux_st_t;
	ccs_mux_st_t s;
	ccs_mux_st_t n;
	logic tgt;

	// Old source is cut first, new one taken on its own first tick
	always_comb
	begin
		n = s;
		n.tick = 1'b0;
		tgt = use_pll ? tick_pll : tick_ext;
		if (s.busy)
		begin
			if (tgt)
			begin
				n.cur = use_pll; // [R4]
				n.busy = 1'b0;
			end
		end
		else if (use_pll != s.cur)
			n.busy = 1'b1; // [R4]
		else
			n.tick = s.cur ? tick_pll : tick_ext; // [R1]
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else
			s <= n;
	end

	assign mclk_tick = s.tick;
	assign on_pll = s.cur;
	assign busy = s.busy;
endmodule

// *** core/ccs_device.sv ***
// Codec clock selection and ratio checking, device end, AHB-Lite registers.
// Assumes link pins are asynchronous to hclk; the bus has this one slave.
// Functional notes
// R1 - Internal clock from PLL or external input
// R2 - Manual mode, or auto switch on lock loss
// R3 - PLL locks frame clock, outputs 256x
// R4 - Source change is glitch-free
// R5 - Host keeps external clock while not forced
// R6 - Both ports master only on external clock
// R7 - ADC port slave on PLL; DAC may master
// R8 - Host frame clock equals rate, synchronous
// R9 - Synchronous-to-frame slave clocks use PLL
// R10 - Host bit clock 128/64/48/32 times rate
// R11 - External clock twice fastest bit clock
// R12 - Host keeps slave frame clocks running
// R13 - Slave mode: one-line 1 yes, 2 no
// R14 - Legal external clock to frame ratios
// R15 - Legal bit clock to frame ratios
// R16 - Speed mode picks ratio set
// R17 - Force-lock keeps PLL, no auto switch
// R18 - Lock loss visible to software
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ccs_device
	import ccs_pkg::*;
#(
	parameter int unsigned LOST_CYC = LOST_CYC_DEF
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	ccs_link_if.device lnk
);
	typedef struct packed {
		logic [4:0] sy1;
		logic [4:0] sy2;
		logic [4:0] prv;
		ccs_sel_t sel;
		logic pll_ref;
		logic force_lk;
		logic adc_mst;
		logic dac_mst;
		ccs_spd_t speed;
		ccs_fmt_t fmt;
		logic [3:0] irq;
		logic [3:0] mask;
		logic wpend;
		logic [7:0] waddr;
		logic [31:0] rdata;
		logic [15:0] per;
		logic [15:0] last_per;
		logic [1:0] good;
		logic locked;
		logic [16:0] acc;
		logic rclk;
		logic rtick;
		logic [9:0] mcnt;
		logic [9:0] mres;
		logic [7:0] bcnt;
		logic [7:0] bres;
		logic ratio_ok;
		logic [7:0] div;
		logic [1:0] refp;
	} ccs_dev_st_t;
	ccs_dev_st_t s;
	ccs_dev_st_t n;
	logic [4:0] rise;
	logic [3:0] evt;
	logic [15:0] diff;
	logic [17:0] sum;
	logic want;
	logic use_pll;
	logic adc_eff;
	logic lost;
	logic mok;
	logic bok;
	logic mst_bad;
	logic fmt_bad;
	logic mclk_tick;
	logic on_pll;
	logic busy;

	// ****************************************
	// Ratio tables
	// ****************************************
	function automatic logic mclk_ok(input ccs_spd_t spd, input ccs_fmt_t fmt, input logic [9:0] m);
		logic [9:0] b;
		b = MCLK_BASE >> spd; // [R16]
		if (fmt == FMT_ONE1)
			return m == MCLK_ONE_LINE; // [R14]
		return m == b || m == b + (b >> 1) || m == {b[8:0], 1'b0}; // [R14]
	endfunction

	function automatic logic bclk_ok(input ccs_spd_t spd, input ccs_fmt_t fmt, input logic [7:0] c);
		if (fmt == FMT_ONE1)
			return c == BR_128; // [R15]
		return c == BR_32 || c == BR_48 || c == BR_64 || (spd == SPD_SINGLE && c == BR_128); // [R15] [R16]
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		n = s;
		evt = '0;
		diff = '0;
		// Two-flop synchronisers, then edge detect on the second stage
		n.sy1 = {lnk.ext_master_clk_in, lnk.pin};
		n.sy2 = s.sy1;
		n.prv = s.sy2;
		rise = s.sy2 & ~s.prv;

		// Source choice
		unique case (s.sel)
			SEL_MAN_PLL: want = 1'b1; // [R2]
			SEL_MAN_EXT: want = 1'b0; // [R2]
			SEL_AUTO, SEL_AUTO_ALT: want = s.locked; // [R2]
		endcase
		use_pll = s.pll_ref & want; // [R1] [R9]
		adc_eff = s.adc_mst & ~use_pll & ~on_pll & ~busy; // [R6] [R7]
		mst_bad = s.adc_mst & use_pll; // [R7]
		fmt_bad = s.fmt == FMT_ONE2 && (!adc_eff || !s.dac_mst); // [R13]

		// Frame period measure and lock
		lost = s.per >= LOST_CYC[15:0];
		if (rise[P_ADC_FRM])
		begin
			// Count the rise cycle itself so the period reads in whole cycles
			n.per = 16'h0001;
			n.last_per = s.per;
			diff = (s.per > s.last_per) ? s.per - s.last_per : s.last_per - s.per;
			if (diff <= LOCK_TOL)
				n.good = (s.good == LOCK_GOOD) ? s.good : s.good + 2'h1;
			else
				n.good = '0;
		end
		else
		begin
			if (s.per != 16'hffff)
				n.per = s.per + 16'h0001;
			if (lost)
				n.good = '0;
		end
		n.locked = s.force_lk | (s.pll_ref & (s.good == LOCK_GOOD) & ~lost); // [R3] [R17]
		evt[I_LOST] = s.locked & ~n.locked; // [R18]

		// Recovered clock: two toggles per frame period times 256
		n.rtick = 1'b0;
		sum = 18'(s.acc) + NCO_STEP;
		if (s.pll_ref && s.last_per != '0)
		begin
			if (sum >= 18'(s.last_per))
			begin
				n.acc = (s.last_per < NCO_STEP[15:0]) ? '0 : 17'(sum - 18'(s.last_per)); // [R3]
				n.rclk = ~s.rclk;
				n.rtick = ~s.rclk;
			end
			else
				n.acc = 17'(sum);
		end
		else
		begin
			n.acc = '0;
			n.rclk = 1'b0;
		end

		// Ratio counting per ADC frame
		mok = use_pll | mclk_ok(s.speed, s.fmt, s.mcnt); // [R14]
		bok = adc_eff | bclk_ok(s.speed, s.fmt, s.bcnt); // [R15]
		if (rise[P_ADC_FRM])
		begin
			n.mres = s.mcnt;
			n.bres = s.bcnt;
			n.mcnt = {9'h000, rise[P_EXT]};
			n.bcnt = {7'h00, rise[P_ADC_BIT]};
			n.ratio_ok = mok & bok;
			evt[I_RATIO] = ~(mok & bok);
		end
		else
		begin
			if (rise[P_EXT] && s.mcnt != 10'h3ff)
				n.mcnt = s.mcnt + 10'h001;
			if (rise[P_ADC_BIT] && s.bcnt != 8'hff)
				n.bcnt = s.bcnt + 8'h01;
		end

		// Master-mode divider on the internal clock
		if (mclk_tick)
			n.div = s.div + 8'h01;

		// Refusals, flagged once per onset
		n.refp = {fmt_bad, mst_bad};
		evt[I_MST] = mst_bad & ~s.refp[0];
		evt[I_FMT] = fmt_bad & ~s.refp[1];

		// Bus write in the data phase
		n.wpend = hsel & hready & htrans[1] & hwrite;
		n.waddr = haddr[7:0];
		if (s.wpend)
		begin
			case (s.waddr)
				A_CTRL:
				begin
					n.sel = ccs_sel_t'(hwdata[C_SEL +: 2]);
					n.pll_ref = hwdata[C_PLL_REF];
					n.force_lk = hwdata[C_FORCE];
					n.adc_mst = hwdata[C_ADC_MST];
					n.dac_mst = hwdata[C_DAC_MST];
					n.speed = ccs_spd_t'(hwdata[C_SPEED +: 2]);
					n.fmt = ccs_fmt_t'(hwdata[C_FMT +: 2]);
				end
				A_IRQ: n.irq = s.irq & ~hwdata[3:0];
				A_MASK: n.mask = hwdata[3:0];
				default: ;
			endcase
		end
		n.irq = n.irq | evt;

		// Read data taken in the address phase, after any write before it, except the STAT master bits
		if (hsel && hready && htrans[1] && !hwrite)
		begin
			case (haddr[7:0])
				A_CTRL: n.rdata = {22'h000000, n.fmt, n.speed, n.dac_mst, n.adc_mst, n.force_lk, n.pll_ref, n.sel};
				A_STAT: n.rdata = {n.last_per, 10'h000, n.ratio_ok, s.dac_mst, adc_eff, busy, on_pll, s.locked}; // [R18]
				A_IRQ: n.rdata = {28'h0000000, n.irq};
				A_MASK: n.rdata = {28'h0000000, n.mask};
				A_RATIO: n.rdata = {8'h00, n.bres, 6'h00, n.mres};
				default: n.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else
			s <= n;
	end

	// ****************************************
	// Clock switch and outputs
	// ****************************************
	ccs_clk_mux u_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_pll(s.rtick),
		.tick_ext(rise[P_EXT]),
		.use_pll(use_pll),
		.mclk_tick(mclk_tick),
		.on_pll(on_pll),
		.busy(busy)
	);

	// Master clocks: bit clock is internal clock / 4, frame is / 256
	assign lnk.dev_o = {s.div[DIV_BCLK], s.div[DIV_FRM], s.div[DIV_BCLK], s.div[DIV_FRM]};
	assign lnk.dev_oe = {s.dac_mst, s.dac_mst, adc_eff, adc_eff}; // [R6] [R7]
	assign lnk.recovered_clk_out = s.rclk; // [R3]
	assign hrdata = s.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = |(s.irq & s.mask);
endmodule

// *** core/ccs_host.sv ***
// Audio processor end: makes the external master clock and slave clocks.
// Assumes user controls are static while frames run.
`timescale 1ns/1ps
module ccs_host
	import ccs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic mclk_en,
	input wire logic adc_drive,
	input wire logic dac_drive,
	input wire logic [7:0] bits_per_frame,
	output logic adc_frame_seen,
	output logic dac_frame_seen,
	output logic rec_clk_seen,
	ccs_link_if.host lnk
);
	typedef struct packed {
		logic mclk;
		logic [1:0] cyc;
		logic bclk;
		logic [7:0] bitn;
		logic frm;
		logic [2:0] sy1;
		logic [2:0] sy2;
	} ccs_host_st_t;
	ccs_host_st_t s;
	ccs_host_st_t n;

	// Clock generation from hclk by division
	always_comb
	begin
		n = s;
		n.mclk = mclk_en & ~s.mclk; // [R5] [R11]
		n.sy1 = {lnk.recovered_clk_out, lnk.pin[P_DAC_FRM], lnk.pin[P_ADC_FRM]};
		n.sy2 = s.sy1;
		if (s.cyc == HOST_HALF_M1)
		begin
			n.cyc = '0;
			n.bclk = ~s.bclk;
			// Bit and frame advance on the falling bit clock edge
			if (s.bclk)
			begin
				n.bitn = (s.bitn >= bits_per_frame - 8'h01) ? '0 : s.bitn + 8'h01; // [R10] [R15]
				n.frm = n.bitn < {1'b0, bits_per_frame[7:1]}; // [R8] [R12] [R14]
			end
		end
		else
			n.cyc = s.cyc + 2'h1;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= '0;
		else
			s <= n;
	end

	assign lnk.ext_master_clk_in = s.mclk;
	assign lnk.host_o = {s.bclk, s.frm, s.bclk, s.frm};
	assign lnk.host_oe = {dac_drive, dac_drive, adc_drive, adc_drive};
	assign adc_frame_seen = s.sy2[0];
	assign dac_frame_seen = s.sy2[1];
	assign rec_clk_seen = s.sy2[2];
endmodule

// *** core/ccs_link_if.sv ***
// Link between the codec clock block and the audio processor.
// Assumes the bench reads pin[] as the wire level; nobody driving reads 0.
`timescale 1ns/1ps
interface ccs_link_if;
	logic ext_master_clk_in;
	logic recovered_clk_out;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic [3:0] host_o;
	logic [3:0] host_oe;
	logic [3:0] pin;
	// Wire level of the four frame and bit clocks
	assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o);
	modport device(input ext_master_clk_in, pin, output recovered_clk_out, dev_o, dev_oe);
	modport host(output ext_master_clk_in, host_o, host_oe, input pin, recovered_clk_out);
endinterface

// *** core/ccs_pkg.sv ***
// Constants and types shared by both ends of the codec clock selection link.
// Assumes both ends run from one 40 MHz hclk.
package ccs_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned HCLK_MHZ = 40;
	localparam int unsigned LOST_NS = 500000;
	localparam int unsigned LOST_CYC_DEF = LOST_NS * HCLK_MHZ / 1000;
	localparam logic [15:0] LOCK_TOL = 16'h0004;
	localparam logic [1:0] LOCK_GOOD = 2'h2;
	localparam logic [17:0] NCO_STEP = 18'h00200;
	localparam logic [1:0] HOST_HALF_M1 = 2'h3;
	localparam int DIV_BCLK = 1;
	localparam int DIV_FRM = 7;
	// ****************************************
	// Pin indices (bit 4 is the external master clock)
	// ****************************************
	localparam int P_ADC_FRM = 0;
	localparam int P_ADC_BIT = 1;
	localparam int P_DAC_FRM = 2;
	localparam int P_DAC_BIT = 3;
	localparam int P_EXT = 4;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_IRQ = 8'h08;
	localparam logic [7:0] A_MASK = 8'h0c;
	localparam logic [7:0] A_RATIO = 8'h10;
	localparam int C_SEL = 0;
	localparam int C_PLL_REF = 2;
	localparam int C_FORCE = 3;
	localparam int C_ADC_MST = 4;
	localparam int C_DAC_MST = 5;
	localparam int C_SPEED = 6;
	localparam int C_FMT = 8;
	localparam int S_PER = 16;
	localparam int R_BIT = 16;
	localparam int I_LOST = 0;
	localparam int I_RATIO = 1;
	localparam int I_MST = 2;
	localparam int I_FMT = 3;
	// ****************************************
	// Clock ratios
	// ****************************************
	localparam logic [9:0] MCLK_BASE = 10'h100;
	localparam logic [9:0] MCLK_ONE_LINE = 10'h100;
	localparam logic [7:0] BR_32 = 8'h20;
	localparam logic [7:0] BR_48 = 8'h30;
	localparam logic [7:0] BR_64 = 8'h40;
	localparam logic [7:0] BR_128 = 8'h80;
	typedef enum logic [1:0] {SEL_MAN_PLL = 2'h0, SEL_MAN_EXT = 2'h1, SEL_AUTO = 2'h3, SEL_AUTO_ALT = 2'h2} ccs_sel_t;
	typedef enum logic [1:0] {SPD_SINGLE = 2'h0, SPD_DOUBLE = 2'h1, SPD_QUAD = 2'h2, SPD_BAD = 2'h3} ccs_spd_t;
	typedef enum logic [1:0] {FMT_NORMAL = 2'h0, FMT_ONE1 = 2'h1, FMT_ONE2 = 2'h2, FMT_BAD = 2'h3} ccs_fmt_t;
endpackage

// *** testbench/ccs_link_chk.sv ***
// Assertions on the clock link between the device and host ends.
// Assumes it sees the link signals plus hclk and hresetn.
`timescale 1ns/1ps
module ccs_link_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ext_master_clk_in,
	input wire logic recovered_clk_out,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe,
	input wire logic [3:0] host_o,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] pin
);
	// ****************************************
	// Link timing relations
	// ****************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_ext_clk_rate: assert property (ext_master_clk_in |=> !ext_master_clk_in)
		else $error("external clock high for more than one cycle");
	a_bit_high_len: assert property ($rose(host_o[1]) && host_oe[1] |-> (host_o[1] || !host_oe[1])[*4] ##1 !host_o[1])
		else $error("host bit clock high phase not four cycles");
	a_bit_low_len: assert property ($fell(host_o[1]) && host_oe[1] |-> (!host_o[1] || !host_oe[1])[*4])
		else $error("host bit clock low phase too short");
	a_host_oe_pair: assert property (host_oe[0] == host_oe[1] && host_oe[2] == host_oe[3])
		else $error("host drives a frame clock without its bit clock");
	a_dev_oe_pair: assert property (dev_oe[0] == dev_oe[1] && dev_oe[2] == dev_oe[3])
		else $error("device drives a frame clock without its bit clock");
	a_dev_wins: assert property (dev_oe[0] |-> pin[0] == dev_o[0])
		else $error("device frame clock not on the wire");
	a_rec_rate: assert property ($rose(recovered_clk_out) |=> !recovered_clk_out)
		else $error("recovered clock slower than expected");
	a_rst_quiet: assert property ($rose(hresetn) |-> dev_oe == 4'h0 && !recovered_clk_out)
		else $error("link outputs active right after reset");
endmodule

// *** testbench/codec_clock_select_and_ratio_tb.sv ***
// Bench joining device and host ends through the link interface.
// Assumes zero-wait AHB-Lite slave and a shortened lock-loss count.
`timescale 1ns/1ps
module codec_clock_select_and_ratio_tb;
	import ccs_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, mclk_en, adc_drive, dac_drive;
	logic [31:0] haddr, hwdata, hrdata, q, rnd;
	logic [1:0] htrans;
	logic [7:0] bits;
	logic rec_seen;
	int fails, comparisons, cyc, s;
	ccs_link_if lnk();
	ccs_device #(.LOST_CYC(2000)) u_ccs_device(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .irq(irq), .lnk(lnk));
	ccs_host u_ccs_host(.hclk(hclk), .hresetn(hresetn), .mclk_en(mclk_en), .adc_drive(adc_drive),
		.dac_drive(dac_drive), .bits_per_frame(bits), .adc_frame_seen(), .dac_frame_seen(),
		.rec_clk_seen(rec_seen), .lnk(lnk));
	ccs_link_chk u_ccs_link_chk(.hclk(hclk), .hresetn(hresetn), .ext_master_clk_in(lnk.ext_master_clk_in),
		.recovered_clk_out(lnk.recovered_clk_out), .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe),
		.host_o(lnk.host_o), .host_oe(lnk.host_oe), .pin(lnk.pin));
	// ****************************************
	// Clock, timeout and helpers
	// ****************************************
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Cut a hung run short
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Model: legal slave ratios for a speed mode
	function automatic logic ratio_ok(input int sp, input int e, input int b);
		int base;
		base = 256 >> sp;
		return (e == base || e == base * 3 / 2 || e == base * 2) && (b == 32 || b == 48 || b == 64 || (b == 128 && sp == 0));
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// One AHB-Lite single transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	// Read until masked value matches, then compare
	task automatic poll(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int k;
		logic [31:0] r;
		k = 0;
		do
		begin
			bus(1'b0, a, 32'h0, r);
			k++;
		end
		while ((r & m) !== v && k < 1500);
		chk(n, v, r & m);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{mclk_en, adc_drive, dac_drive} = 3'h0;
		bits = 8'h40;
		rnd = 32'h3303;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, unmapped word included
		for (s = 0; s < 6; s++)
			poll("reset word", 8'(s * 4), 32'hffffffff, 32'h0);
		rnd = lfsr(rnd);
		wr(A_MASK, rnd & 32'hf);
		poll("mask", A_MASK, 32'hf, rnd & 32'hf);
		wr(A_MASK, 32'h0);
		// PLL locks to host frames, 512 cycles each
		mclk_en <= 1'b1;
		adc_drive <= 1'b1;
		dac_drive <= 1'b1;
		wr(A_CTRL, 32'h4);
		poll("lock on pll", A_STAT, 32'h3, 32'h3);
		poll("period", A_STAT, 32'hffff0000, 32'h02000000);
		// Recovered clock at 256 per 512-cycle frame toggles every cycle
		s = 0;
		repeat (8)
		begin
			@(posedge hclk);
			s += rec_seen;
		end
		chk("rec clk highs", 32'h4, s);
		chk("hresp", 32'h0, {31'h0, hresp});
		// ADC master refused on PLL
		wr(A_CTRL, 32'h14);
		poll("adc refused", A_IRQ, 32'h4, 32'h4);
		poll("adc not master", A_STAT, 32'h8, 32'h0);
		wr(A_MASK, 32'h4);
		#1 chk("irq", 32'h1, {31'h0, irq});
		wr(A_IRQ, 32'h4);
		#1 chk("irq clear", 32'h0, {31'h0, irq});
		wr(A_MASK, 32'h0);
		// Ratio table per speed on external clock
		for (s = 0; s < 3; s++)
		begin
			wr(A_CTRL, 32'h1 | (s << C_SPEED));
			poll("ratio ok", A_STAT, 32'h20, ratio_ok(s, 256, 64) ? 32'h20 : 32'h0);
		end
		wr(A_CTRL, 32'h1);
		poll("ratio reg", A_RATIO, 32'h00ff03ff, 32'h00400100);
		adc_drive <= 1'b0;
		bits <= 8'h10;
		wr(A_IRQ, 32'hf);
		adc_drive <= 1'b1;
		poll("ratio err", A_IRQ, 32'h2, ratio_ok(0, 64, 16) ? 32'h0 : 32'h2);
		wr(A_CTRL, 32'h201);
		poll("one line two", A_IRQ, 32'h8, 32'h8);
		// Auto switch on lock loss
		adc_drive <= 1'b0;
		bits <= 8'h40;
		wr(A_CTRL, 32'h6);
		adc_drive <= 1'b1;
		poll("auto lock", A_STAT, 32'h3, 32'h3);
		wr(A_IRQ, 32'hf);
		adc_drive <= 1'b0;
		poll("auto to ext", A_STAT, 32'h7, 32'h0);
		poll("lost flag", A_IRQ, 32'h1, 32'h1);
		// Force-lock keeps PLL without frames
		wr(A_CTRL, 32'he);
		poll("forced", A_STAT, 32'h3, 32'h3);
		// Both ports master on external clock
		dac_drive <= 1'b0;
		wr(A_CTRL, 32'h31);
		poll("both master", A_STAT, 32'h18, 32'h18);
		summarize();
	end
endmodule
